// file: core/timer_cfg.svh
// Functional notes
// - Toggle flop inverts on a comparator match when inversion is enabled.
// - Invert-enable bit gates match inversion; cleared means matches leave flop alone.
// - Toggle flop value after reset is undefined; a known zero is used.
// - Toggle command write: 01 clears, 10 sets, 00 inverts the flop.
// - Toggle control reads return ones in bits 7:5 and 3:2.
// - 8-bit mode gives two independent timers with own counter, compare, interrupt.
// - Timer zero: external, div1/4/16; timer one: match zero, div1/16/256.
// - Timer one may count each match pulse of timer zero.
// - Pair-mode field 01 joins both timers into one 16-bit timer.
// - In 16-bit mode timer zero overflow clocks timer one, ignoring selection.
// - In 16-bit mode compare zero is low byte, compare one high byte.
// - Compare zero write suspends comparison until compare one is written.
// - In 16-bit mode timer zero match does not clear its counter.
// - Both matching clears both counters, raises timer one irq, may toggle.
// - Pulse mode drives the output from timer zero; timer one unused.
// - Pulse polarity is chosen by the flop level software preloads.
// - Pulse output inverts at compare zero and again at compare one.
// - In pulse mode with double buffer on, buffer loads compare zero at compare one match.
// - Interval match clears the matching counter and raises its interrupt.
// - Compare value zero matches at counter overflow, not at zero count.
// - Double buffer resets off; off writes both, on writes buffer only.
// - Run register starts, stops and clears counters; reset clears and stops.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define ADDR_RUN 3'h0
`define ADDR_MODE 3'h1
`define ADDR_TOGGLE 3'h2
`define ADDR_CMP0 3'h3
`define ADDR_CMP1 3'h4
`define ADDR_CNT0 3'h5
`define ADDR_CNT1 3'h6
`define ADDR_STATUS 3'h7
`define RUN_T0_BIT 0
`define RUN_T1_BIT 1
`define MODE_LCLK_RNG 1:0
`define MODE_UCLK_RNG 3:2
`define MODE_PAIR_RNG 7:6
`define TOG_SEL_BIT 0
`define TOG_IE_BIT 1
`define TOG_CMD_RNG 3:2
`define TOG_DOUBLE_BUFFER_ENABLE_BIT 4
`define TOG_ONES_HI 3'h7
`define TOG_ONES_LO 2'h3
`define BYTE_ZERO 8'h00
`define CNT_STEP 8'h01
`define CNT16_STEP 16'h0001
`endif

// file: core/timer_pkg.sv
`default_nettype none
package timer_pkg;
  typedef enum logic [1:0] {
    PAIR_8BIT = 2'b00,
    PAIR_16BIT = 2'b01,
    PAIR_PPG = 2'b10,
    PAIR_PWM = 2'b11
  } pair_mode_e;
  typedef enum logic [1:0] {
    TOG_CMD_INVERT = 2'b00,
    TOG_CMD_CLEAR = 2'b01,
    TOG_CMD_SET = 2'b10,
    TOG_CMD_NONE = 2'b11
  } toggle_cmd_e;
  typedef logic [7:0] byte_t;
endpackage : timer_pkg
`default_nettype wire

// file: core/timer_if.sv
`default_nettype none
interface timer_if;
  logic tick;
  logic run;
  logic clr;
  logic clear_on_match;
  timer_pkg::byte_t cmp;
  timer_pkg::byte_t cnt;
  logic match;
  logic ovf;
  modport ctrl (output tick, run, clr, clear_on_match, cmp,
                input cnt, match, ovf);
  modport unit (input tick, run, clr, clear_on_match, cmp,
                output cnt, match, ovf);
endinterface : timer_if
`default_nettype wire

// file: core/timer_unit.sv
`include "timer_cfg.svh"
`default_nettype none
module timer_unit (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  timer_if.unit bus
);
  timer_pkg::byte_t cnt_q;
  timer_pkg::byte_t cnt_d;

  // Next count wraps in 8 bits, so a compare of zero hits on overflow
  assign cnt_d = cnt_q + `CNT_STEP;
  assign bus.match = bus.tick && bus.run && (cnt_d == bus.cmp);
  assign bus.ovf = bus.tick && bus.run && (cnt_d == `BYTE_ZERO);
  assign bus.cnt = cnt_q;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= `BYTE_ZERO;
    end else if (!bus.run || bus.clr) begin
      cnt_q <= `BYTE_ZERO;
    end else if (bus.match && bus.clear_on_match) begin
      cnt_q <= `BYTE_ZERO;
    end else if (bus.tick) begin
      cnt_q <= cnt_d;
    end
  end
endmodule : timer_unit
`default_nettype wire

// file: core/dual_timer.sv
// Our own choices: the register addresses and the strobed register port.
`include "timer_cfg.svh"
`default_nettype none
module dual_timer (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic i_external_count_input,
  input wire logic i_prescale_tap_div1,
  input wire logic i_prescale_tap_div4,
  input wire logic i_prescale_tap_div16,
  input wire logic i_prescale_tap_div256,
  output logic [7:0] o_rd_data,
  output logic o_timer_output_pin,
  output logic o_timer_zero_irq,
  output logic o_timer_one_irq
);
  timer_if u0 ();
  timer_if u1 ();

  logic [1:0] run_q;
  timer_pkg::byte_t mode_q;
  logic double_buffer_enable_q;
  logic inv_en_q;
  logic inv_sel_q;
  timer_pkg::byte_t cmp0_q;
  timer_pkg::byte_t cmp0_buf_q;
  timer_pkg::byte_t cmp1_q;
  logic cmp_hold_q;
  logic shared_toggle_flop_q;
  logic irq0_q;
  logic irq1_q;
  timer_pkg::byte_t rd_data_q;
  logic [2:0] ext_sync_q;
  logic ext_lvl_q;
  logic ext_tick_q;

  timer_pkg::pair_mode_e pair_mode;
  logic is16;
  logic isppg;
  logic tick0;
  logic tick1;
  logic m16;
  logic ppg_lo;
  logic ev0;
  logic ev1;
  logic tog_ev;
  logic wr_run;
  logic wr_mode;
  logic wr_tog;
  logic wr_cmp0;
  logic wr_cmp1;
  logic [15:0] cnt16_d;
  timer_pkg::toggle_cmd_e tog_cmd;

  // Clock source pick; same decode serves both timers
  function automatic logic sel_tick(input logic [1:0] sel,
                                    input logic s0, input logic s1,
                                    input logic s2, input logic s3);
    logic r;
    r = 1'b0;
    case (sel)
      2'b00: r = s0;
      2'b01: r = s1;
      2'b10: r = s2;
      default: r = s3;
    endcase
    return r;
  endfunction : sel_tick

  // Register write decode
  assign wr_run = i_wr_stb && (i_addr == `ADDR_RUN);
  assign wr_mode = i_wr_stb && (i_addr == `ADDR_MODE);
  assign wr_tog = i_wr_stb && (i_addr == `ADDR_TOGGLE);
  assign wr_cmp0 = i_wr_stb && (i_addr == `ADDR_CMP0);
  assign wr_cmp1 = i_wr_stb && (i_addr == `ADDR_CMP1);
  assign tog_cmd = timer_pkg::toggle_cmd_e'(i_wr_data[`TOG_CMD_RNG]);

  // Mode decode; the unsupported PWM code behaves as plain 8-bit mode
  assign pair_mode = timer_pkg::pair_mode_e'(mode_q[`MODE_PAIR_RNG]);
  assign is16 = (pair_mode == timer_pkg::PAIR_16BIT);
  assign isppg = (pair_mode == timer_pkg::PAIR_PPG);

  // External count input: three flops, edge counted once two stages agree
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], i_external_count_input};
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_lvl_q <= 1'b0;
      ext_tick_q <= 1'b0;
    end else begin
      ext_tick_q <= 1'b0;
      if (ext_sync_q[1] == ext_sync_q[2]) begin
        ext_lvl_q <= ext_sync_q[2];
        ext_tick_q <= ext_sync_q[2] && !ext_lvl_q;
      end
    end
  end

  // Timer zero clock: external, div1, div4, div16
  assign tick0 = sel_tick(mode_q[`MODE_LCLK_RNG], ext_tick_q,
                          i_prescale_tap_div1, i_prescale_tap_div4,
                          i_prescale_tap_div16);

  // Timer one clock: overflow in 16-bit mode, else selected source
  assign tick1 = is16 ? u0.ovf :
                 sel_tick(mode_q[`MODE_UCLK_RNG], u0.match,
                          i_prescale_tap_div1, i_prescale_tap_div16,
                          i_prescale_tap_div256);

  // In pulse mode the lower counter wraps at compare one
  assign u0.tick = tick0;
  assign u0.run = run_q[`RUN_T0_BIT] && (!isppg || run_q[`RUN_T1_BIT]);
  assign u0.cmp = isppg ? cmp1_q : cmp0_q;
  assign u0.clear_on_match = !is16;
  assign u0.clr = m16;

  // Upper counter idles in pulse mode but its run bit still gates the lower counter
  assign u1.tick = tick1;
  assign u1.run = run_q[`RUN_T1_BIT] && !isppg;
  assign u1.cmp = cmp1_q;
  assign u1.clear_on_match = !is16;
  assign u1.clr = m16;

  timer_unit timer0 (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .bus(u0)
  );

  timer_unit timer1 (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .bus(u1)
  );

  // 16-bit check: low byte from compare zero, high from compare one
  assign cnt16_d = {u1.cnt, u0.cnt} + `CNT16_STEP;
  assign m16 = is16 && !cmp_hold_q && u0.tick && u0.run && u1.run &&
               (cnt16_d == {cmp1_q, cmp0_q});

  // Pulse mode first edge where the lower counter meets compare zero
  assign ppg_lo = isppg && u0.tick && u0.run &&
                  ((u0.cnt + `CNT_STEP) == cmp0_q);

  // Event routing by mode
  assign ev0 = !is16 && u0.match;
  assign ev1 = is16 ? m16 : (!isppg && u1.match);
  assign tog_ev = is16 ? m16 :
                  isppg ? (u0.match || ppg_lo) :
                  (inv_sel_q ? u1.match : u0.match);

  // Control registers
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_q <= 2'h0;
      mode_q <= `BYTE_ZERO;
    end else begin
      if (wr_run) begin
        run_q <= {i_wr_data[`RUN_T1_BIT], i_wr_data[`RUN_T0_BIT]};
      end
      if (wr_mode) begin
        mode_q <= i_wr_data;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      double_buffer_enable_q <= 1'b0;
      inv_en_q <= 1'b0;
      inv_sel_q <= 1'b0;
    end else if (wr_tog) begin
      double_buffer_enable_q <= i_wr_data[`TOG_DOUBLE_BUFFER_ENABLE_BIT];
      inv_en_q <= i_wr_data[`TOG_IE_BIT];
      inv_sel_q <= i_wr_data[`TOG_SEL_BIT];
    end
  end

  // Compare registers and double buffer
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmp0_q <= `BYTE_ZERO;
      cmp0_buf_q <= `BYTE_ZERO;
      cmp1_q <= `BYTE_ZERO;
    end else begin
      if (wr_cmp0) begin
        cmp0_buf_q <= i_wr_data;
      end
      if (wr_cmp0 && !double_buffer_enable_q) begin
        cmp0_q <= i_wr_data;
      end else if (isppg && double_buffer_enable_q && u0.match) begin
        cmp0_q <= cmp0_buf_q;
      end
      if (wr_cmp1) begin
        cmp1_q <= i_wr_data;
      end
    end
  end

  // Suspension between the two byte writes
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmp_hold_q <= 1'b0;
    end else if (wr_cmp1) begin
      cmp_hold_q <= 1'b0;
    end else if (wr_cmp0) begin
      cmp_hold_q <= 1'b1;
    end
  end

  // Shared toggle flop; software command beats a match in the same cycle.
  // The level software preloads sets the pulse polarity.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shared_toggle_flop_q <= 1'b0;
    end else if (wr_tog) begin
      case (tog_cmd)
        timer_pkg::TOG_CMD_CLEAR: shared_toggle_flop_q <= 1'b0;
        timer_pkg::TOG_CMD_SET: shared_toggle_flop_q <= 1'b1;
        timer_pkg::TOG_CMD_INVERT: begin
          shared_toggle_flop_q <= !shared_toggle_flop_q;
        end
        default: shared_toggle_flop_q <= shared_toggle_flop_q;
      endcase
    end else if (inv_en_q && tog_ev) begin
      shared_toggle_flop_q <= !shared_toggle_flop_q;
    end
  end

  // Interrupt request pulses, one cycle per event
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
    end else begin
      irq0_q <= ev0;
      irq1_q <= ev1;
    end
  end

  // Read port; compare registers are write-only and read as zero
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_data_q <= `BYTE_ZERO;
    end else if (i_rd_stb) begin
      case (i_addr)
        `ADDR_RUN: rd_data_q <= {6'h00, run_q};
        `ADDR_MODE: rd_data_q <= mode_q;
        `ADDR_TOGGLE: begin
          rd_data_q <= {`TOG_ONES_HI, double_buffer_enable_q, `TOG_ONES_LO,
                        inv_en_q, inv_sel_q};
        end
        `ADDR_CNT0: rd_data_q <= u0.cnt;
        `ADDR_CNT1: rd_data_q <= u1.cnt;
        `ADDR_STATUS: begin
          rd_data_q <= {6'h00, cmp_hold_q, shared_toggle_flop_q};
        end
        default: rd_data_q <= `BYTE_ZERO;
      endcase
    end else begin
      rd_data_q <= `BYTE_ZERO;
    end
  end

  // Pin follows the flop; port routing lives outside this block
  assign o_timer_output_pin = shared_toggle_flop_q;
  assign o_timer_zero_irq = irq0_q;
  assign o_timer_one_irq = irq1_q;
  assign o_rd_data = rd_data_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_match_toggle;
    inv_en_q && tog_ev && !wr_tog |=>
      shared_toggle_flop_q != $past(shared_toggle_flop_q);
  endproperty
  a_match_toggle: assert property (p_match_toggle)
    else $error("toggle flop missed a match");

  property p_no_toggle;
    !inv_en_q && !wr_tog |=> $stable(shared_toggle_flop_q);
  endproperty
  a_no_toggle: assert property (p_no_toggle)
    else $error("toggle flop moved while inversion disabled");

  property p_cmd_clear;
    wr_tog && tog_cmd == timer_pkg::TOG_CMD_CLEAR |=>
      !o_timer_output_pin;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear)
    else $error("clear command did not clear flop");

  property p_cmd_set;
    wr_tog && tog_cmd == timer_pkg::TOG_CMD_SET |=> o_timer_output_pin;
  endproperty
  a_cmd_set: assert property (p_cmd_set)
    else $error("set command did not set flop");

  property p_ones_read;
    i_rd_stb && i_addr == `ADDR_TOGGLE |=>
      o_rd_data[7:5] == `TOG_ONES_HI && o_rd_data[3:2] == `TOG_ONES_LO;
  endproperty
  a_ones_read: assert property (p_ones_read)
    else $error("toggle control read lost its fixed ones");

  property p_interval_match;
    pair_mode == timer_pkg::PAIR_8BIT && u0.match |=>
      o_timer_zero_irq && u0.cnt == `BYTE_ZERO;
  endproperty
  a_interval_match: assert property (p_interval_match)
    else $error("interval match did not clear and interrupt");

  property p_pair_match;
    m16 |=> o_timer_one_irq && u0.cnt == `BYTE_ZERO &&
            u1.cnt == `BYTE_ZERO;
  endproperty
  a_pair_match: assert property (p_pair_match)
    else $error("16-bit match did not clear both counters");

  property p_hold;
    is16 && cmp_hold_q |=> !o_timer_one_irq;
  endproperty
  a_hold: assert property (p_hold)
    else $error("comparison ran while suspended");

  property p_reload;
    isppg && double_buffer_enable_q && u0.match && !wr_cmp0 |=>
      cmp0_q == $past(cmp0_buf_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("buffer did not load compare zero");

  property p_stopped;
    !run_q[`RUN_T0_BIT] ##1 !run_q[`RUN_T0_BIT] |->
      u0.cnt == `BYTE_ZERO ##1 !o_timer_zero_irq;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped timer counted or interrupted");

  c_interval: cover property (ev0 ##1 o_timer_zero_irq);
  c_pair: cover property (m16 ##1 o_timer_one_irq);
  c_ppg: cover property (ppg_lo ##[1:300] (isppg && u0.match));
  c_reload: cover property (isppg && double_buffer_enable_q && u0.match);
endmodule : dual_timer
`default_nettype wire

// file: verification/dual_8bit_timer_toggle_ppg_tb.sv
`include "timer_cfg.svh"
`default_nettype none
module dual_8bit_timer_toggle_ppg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_stb = 1'b0;
  logic i_rd_stb = 1'b0;
  logic ext_in = 1'b0;
  logic tap_div1 = 1'b0;
  logic tap_div4 = 1'b0;
  logic tap_div16 = 1'b0;
  logic tap_div256 = 1'b0;
  logic [7:0] pre_q = 8'h00;
  logic [7:0] o_rd_data;
  logic o_timer_output_pin;
  logic o_timer_zero_irq;
  logic o_timer_one_irq;
  logic rd_pend = 1'b0;
  logic [15:0] e_w;
  logic [15:0] exp_q[$];
  logic [31:0] r_w;
  logic [1:0] cmds [4] = '{2'b01, 2'b10, 2'b00, 2'b00};
  logic flops [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int taps0 [4] = '{1, 1, 4, 16};
  int taps1 [4] = '{1, 1, 16, 256};
  integer seed = 32'h8926;
  int error_cnt = 0;
  int samples_checked = 0;
  int irq0_n = 0;
  int irq1_n = 0;
  int b0;
  int b1;

  dual_timer dut_u (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb),
    .i_rd_stb(i_rd_stb),
    .i_external_count_input(ext_in),
    .i_prescale_tap_div1(tap_div1),
    .i_prescale_tap_div4(tap_div4),
    .i_prescale_tap_div16(tap_div16),
    .i_prescale_tap_div256(tap_div256),
    .o_rd_data(o_rd_data),
    .o_timer_output_pin(o_timer_output_pin),
    .o_timer_zero_irq(o_timer_zero_irq),
    .o_timer_one_irq(o_timer_one_irq)
  );

  initial begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // Free-running stand-in for the shared prescaler taps
  always @(posedge i_ref_clk) begin
    pre_q <= pre_q + 8'h01;
    tap_div1 <= 1'b1;
    tap_div4 <= (pre_q[1:0] == 2'h3);
    tap_div16 <= (pre_q[3:0] == 4'hF);
    tap_div256 <= (pre_q == 8'hFF);
  end

  // Read data stand only one cycle, so the note is taken off right then
  always @(posedge i_ref_clk) begin
    if (o_timer_zero_irq === 1'b1) irq0_n++;
    if (o_timer_one_irq === 1'b1) irq1_n++;
    if (rd_pend) begin
      e_w = exp_q.pop_front();
      chk_byte(o_rd_data, e_w[15:8], e_w[7:0]);
    end
    rd_pend <= i_rd_stb;
  end

  task automatic chk_byte(input logic [7:0] got, exp, msk);
    samples_checked++;
    if ((got & msk) !== (exp & msk)) begin
      error_cnt++;
      $display("mismatch %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      error_cnt++;
      $display("mismatch %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : wait_n

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e, m);
    exp_q.push_back({e, m});
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
  endtask : rd

  task automatic measure(input int exp);
    int hi;
    hi = 0;
    repeat (50) begin
      @(posedge i_ref_clk);
      if (o_timer_output_pin === 1'b1) hi++;
    end
    chk_cnt(hi, exp);
  endtask : measure

  // Window ends mid-period so tap phase cannot shift the match count
  task automatic interval(input bit tim, input logic [1:0] sel, input int d);
    int c;
    int w;
    int p0;
    int p1;
    // Six ticks a period at least, or the stop write catches a fourth match
    c = 6 + ($unsigned($random(seed)) % 4);
    w = c * d;
    wr(`ADDR_RUN, 8'h00);
    wr(`ADDR_MODE, tim ? {4'h0, sel, 2'b01} : {6'h00, sel});
    // Buffering off first, else the compare write only fills the buffer
    wr(`ADDR_TOGGLE, {6'h01, 1'b1, tim});
    wr(tim ? `ADDR_CMP1 : `ADDR_CMP0, c[7:0]);
    p0 = irq0_n;
    p1 = irq1_n;
    wr(`ADDR_RUN, tim ? 8'h02 : 8'h01);
    wait_n(3 * w + w / 2);
    wr(`ADDR_RUN, 8'h00);
    wait_n(3);
    chk_cnt(tim ? irq1_n - p1 : irq0_n - p0, 3);
    chk_cnt(tim ? irq0_n - p0 : irq1_n - p1, 0);
    rd(`ADDR_STATUS, 8'h01, 8'h01);
    rd(tim ? `ADDR_CNT1 : `ADDR_CNT0, 8'h00, 8'hFF);
  endtask : interval

  task automatic run_span(input int n);
    b0 = irq0_n;
    b1 = irq1_n;
    wr(`ADDR_RUN, 8'h03);
    wait_n(n);
    wr(`ADDR_RUN, 8'h00);
    wait_n(3);
  endtask : run_span

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (40000) @(posedge i_ref_clk);
    error_cnt++;
    $display("mismatch %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd(`ADDR_TOGGLE, 8'hEC, 8'hFF);
    rd(`ADDR_CNT0, 8'h00, 8'hFF);
    rd(`ADDR_CNT1, 8'h00, 8'hFF);
    r_w = $random(seed);
    wr(`ADDR_CNT0, r_w[7:0]);
    rd(`ADDR_CNT0, 8'h00, 8'hFF);
    wr(`ADDR_CMP0, r_w[15:8]);
    rd(`ADDR_CMP0, 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_TOGGLE, {4'h0, cmds[i], 2'b00});
      rd(`ADDR_STATUS, {7'h00, flops[i]}, 8'h01);
      chk_byte({7'h00, o_timer_output_pin}, {7'h00, flops[i]}, 8'h01);
    end
    wr(`ADDR_TOGGLE, 8'h1F);
    rd(`ADDR_TOGGLE, 8'hFF, 8'hFF);
    for (int s = 1; s < 4; s++) interval(1'b0, s[1:0], taps0[s]);
    for (int s = 1; s < 4; s++) interval(1'b1, s[1:0], taps1[s]);
    wr(`ADDR_TOGGLE, 8'h0C);
    wr(`ADDR_MODE, 8'h01);
    wr(`ADDR_CMP0, 8'h03);
    wr(`ADDR_CMP1, 8'h02);
    run_span(20);
    rd(`ADDR_STATUS, 8'h01, 8'h01);
    b0 = irq0_n;
    b1 = irq1_n;
    wait_n(50);
    chk_cnt(irq0_n + irq1_n - b0 - b1, 0);
    run_span(17);
    chk_cnt(irq0_n - b0, 6);
    chk_cnt(irq1_n - b1, 3);
    wr(`ADDR_CMP0, 8'h00);
    run_span(300);
    chk_cnt(irq0_n - b0, 1);
    // Upper clock select set to a slow tap that 16-bit mode must ignore
    wr(`ADDR_MODE, 8'h4D);
    wr(`ADDR_TOGGLE, 8'h06);
    wr(`ADDR_CMP0, 8'h05);
    wr(`ADDR_CMP1, 8'h01);
    run_span(390);
    chk_cnt(irq1_n - b1, 1);
    chk_cnt(irq0_n - b0, 0);
    rd(`ADDR_STATUS, 8'h01, 8'h01);
    wr(`ADDR_CMP0, 8'h05);
    run_span(390);
    chk_cnt(irq1_n - b1, 0);
    wr(`ADDR_CMP1, 8'h01);
    run_span(390);
    chk_cnt(irq1_n - b1, 1);
    for (int p = 0; p < 2; p++) begin
      wr(`ADDR_RUN, 8'h00);
      wr(`ADDR_MODE, 8'h81);
      wr(`ADDR_TOGGLE, p ? 8'h0A : 8'h06);
      wr(`ADDR_CMP0, 8'h02);
      wr(`ADDR_CMP1, 8'h05);
      wr(`ADDR_RUN, 8'h03);
      wait_n(20);
      measure(p ? 20 : 30);
      // Stopped first: a control write racing a match would drop the edge
      wr(`ADDR_RUN, 8'h00);
      wr(`ADDR_TOGGLE, p ? 8'h1A : 8'h16);
      wr(`ADDR_CMP0, 8'h01);
      wr(`ADDR_RUN, 8'h03);
      wait_n(20);
      measure(p ? 10 : 40);
    end
    wr(`ADDR_RUN, 8'h00);
    wr(`ADDR_MODE, 8'h00);
    // Buffer left on by the pulse tests must be off before the compare write
    wr(`ADDR_TOGGLE, 8'h0C);
    wr(`ADDR_CMP0, 8'h00);
    wr(`ADDR_RUN, 8'h01);
    repeat (7) begin
      ext_in <= 1'b1;
      wait_n(4);
      ext_in <= 1'b0;
      wait_n(4);
    end
    wait_n(8);
    rd(`ADDR_CNT0, 8'h07, 8'hFF);
    // Last read data arrive a cycle later; let the watcher compare them
    wait_n(2);
    report_and_stop();
  end
endmodule : dual_8bit_timer_toggle_ppg_tb
`default_nettype wire
